/* logic/ifp_consts.vh */
`ifndef IFP_CONSTS_VH
`define IFP_CONSTS_VH

// ----------------------------------------------------------------------
// special function register addresses
// ----------------------------------------------------------------------
`define IFP_SFR_CHIP_CTRL   8'h9F
`define IFP_SFR_TRIGGER     8'hA4
`define IFP_SFR_ADDR_LOW    8'hA6
`define IFP_SFR_ADDR_HIGH   8'hA7
`define IFP_SFR_DATA        8'hAE
`define IFP_SFR_COMMAND     8'hAF
`define IFP_SFR_TA_KEY      8'hC7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IFP_RST_BYTE        8'h00
`define IFP_ERASED_BYTE     8'hFF

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IFP_GO_BIT          0
`define IFP_CC_SWRST        7
`define IFP_CC_FAULT        6
`define IFP_CC_LOADER_UPDATE_ENABLE        5
`define IFP_CC_BOOTSEL      1
`define IFP_CC_PROG_EN      0
`define IFP_CN_FIRST_CLASS  5
`define IFP_CN_SECOND_CLASS 4
`define IFP_CFG0_LOCK       1
`define IFP_CFG0_BOOTSEL    7

// ----------------------------------------------------------------------
// timed access keys
// ----------------------------------------------------------------------
`define IFP_TA_KEY1         8'hAA
`define IFP_TA_KEY2         8'h55

// ----------------------------------------------------------------------
// operation codes and regions
// ----------------------------------------------------------------------
`define IFP_OP_READ         4'h0
`define IFP_OP_PROG         4'h1
`define IFP_OP_ERASE        4'h2
`define IFP_OP_MFR_ID       4'hB
`define IFP_OP_DEV_ID       4'hC
`define IFP_RGN_MAIN        2'h0
`define IFP_RGN_LOADER      2'h1
`define IFP_RGN_CONFIG      2'h3
`define IFP_FCMD_READ       2'h0
`define IFP_FCMD_PROG       2'h1
`define IFP_FCMD_ERASE      2'h2

// ----------------------------------------------------------------------
// sizes and timing
// ----------------------------------------------------------------------
`define IFP_PAGE_BYTES      16'h0080
`define IFP_CFG_BYTES       16'h0004
`define IFP_RC_FREQ_HZ      22118400

`endif

/* logic/ifp_cfg_mem.v */
`timescale 1ns/1ps
`include "ifp_consts.vh"

// small word store with registered read; cleared to the erased value only at power-on
module ifp_cfg_mem #(
    parameter DW    = 8,
    parameter DEPTH = `IFP_CFG_BYTES,
    parameter AW    = 2
) (
    input  wire          sys_clk,
    input  wire          por_n,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata_q,
    output wire [DW-1:0] word0
);

    wire [DW-1:0] words [0:DEPTH-1];

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1)
        begin : g_word
            reg [DW-1:0] word_q;
            always @(posedge sys_clk or negedge por_n)
            begin
                if (!por_n)
                    word_q <= `IFP_ERASED_BYTE;
                else if (we && (addr == gi))
                    word_q <= wdata;
            end
            assign words[gi] = word_q;
        end
    endgenerate

    always @(posedge sys_clk or negedge por_n)
    begin
        if (!por_n)
            rdata_q <= `IFP_ERASED_BYTE;
        else
            rdata_q <= words[addr];
    end

    assign word0 = words[0];

endmodule // ifp_cfg_mem

/* logic/ifp_top.v */
`timescale 1ns/1ps
`include "ifp_consts.vh"

module ifp_top #(
    parameter [7:0]  MFR_ID    = 8'h3C,  // arbitrary value
    parameter [15:0] DEV_ID    = 16'h1234,  // arbitrary value
    parameter [15:0] MAIN_SIZE = 16'h4000,
    parameter [15:0] LDR_SIZE  = 16'h1000
) (
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire        por_n,
    input  wire [7:0]  sfr_addr,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    input  wire [7:0]  sfr_wdata,
    output reg  [7:0]  sfr_rdata_q,
    input  wire        code_in_loader,
    input  wire        last_reset_sw,
    input  wire        boot_from_loader,
    output reg         cpu_hold_q,
    output wire        rc_osc_en,
    output reg         sw_reset_req_q,
    output reg         boot_next_q,
    output reg         boot_select_active_q,
    output reg         lock_active_q,
    output reg  [7:0]  cfg0_active_q,
    output reg         fl_req_q,
    output reg  [1:0]  fl_cmd_q,
    output reg  [17:0] fl_addr_q,
    output reg  [7:0]  fl_wdata_q,
    input  wire [7:0]  fl_rdata,
    input  wire        fl_done
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_FLASH = 3'd1;
    localparam [2:0] S_CFGRD = 3'd2;
    localparam [2:0] S_CFGLT = 3'd3;
    localparam [2:0] S_CFGWR = 3'd4;
    localparam [2:0] S_CFGER = 3'd5;
    localparam [2:0] S_DONE  = 3'd6;

    localparam [15:0] PAGE_MASK = `IFP_PAGE_BYTES - 16'h0001;
    localparam [15:0] CFG_SIZE  = `IFP_CFG_BYTES;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function is_write;
        input [3:0] op;
        begin
            is_write = (op == `IFP_OP_PROG) || (op == `IFP_OP_ERASE);
        end
    endfunction

    function cmd_ok;
        input [3:0] op;
        input       fc1;
        input       fc2;
        begin
            if (is_write(op))
                cmd_ok = fc1 && !fc2;
            else
                cmd_ok = !fc1 && !fc2 && ((op == `IFP_OP_READ) ||
                         (op == `IFP_OP_MFR_ID) || (op == `IFP_OP_DEV_ID));
        end
    endfunction

    // lock is deliberately not an input here: it never blocks access
    function illegal;
        input [1:0]  rgn;
        input [3:0]  op;
        input [15:0] a;
        input        in_ldr;
        input        loader_update_enable;
        reg          wr;
        begin
            wr = is_write(op);
            illegal = 1'b0;
            if (op == `IFP_OP_DEV_ID)
                illegal = (a > 16'h0001);
            else if (op != `IFP_OP_MFR_ID)
            begin
                case (rgn)
                    `IFP_RGN_MAIN:
                        illegal = (wr && !in_ldr) || (a >= MAIN_SIZE);
                    `IFP_RGN_LOADER:
                        illegal = (wr && in_ldr) || (wr && !in_ldr && !loader_update_enable)
                                  || (a >= LDR_SIZE);
                    `IFP_RGN_CONFIG:
                        illegal = !in_ldr || (a >= CFG_SIZE) ||
                                  ((op == `IFP_OP_ERASE) && (a != 16'h0000));
                    default:
                        illegal = 1'b1;
                endcase
                if ((op == `IFP_OP_ERASE) && (rgn != `IFP_RGN_CONFIG)
                    && ((a & PAGE_MASK) != 16'h0000))
                    illegal = 1'b1;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg  [7:0]  addr_low_q;
    reg  [7:0]  addr_high_q;
    reg  [7:0]  data_q;
    reg  [7:0]  command_q;
    reg         prog_en_q;
    reg         loader_update_enable_q;
    reg         fault_q;
    reg  [1:0]  ta_q;
    reg  [2:0]  state_q;
    reg  [3:0]  op_q;
    reg  [1:0]  cnt_q;
    reg  [1:0]  cap_q;
    reg         mem_we;
    reg  [1:0]  mem_addr;
    reg  [7:0]  mem_wdata;
    wire [7:0]  mem_rdata;
    wire [7:0]  mem_word0;

    wire        wr_ta    = sfr_wr && (sfr_addr == `IFP_SFR_TA_KEY);
    wire        ta_open  = (ta_q == 2'd2);
    wire        wr_cc    = sfr_wr && (sfr_addr == `IFP_SFR_CHIP_CTRL) && ta_open;
    wire        wr_trg   = sfr_wr && (sfr_addr == `IFP_SFR_TRIGGER) && ta_open;
    wire        go       = wr_trg && sfr_wdata[`IFP_GO_BIT] && prog_en_q
                           && (state_q == S_IDLE) && (cap_q == 2'd0);
    wire [17:0] tgt_addr = {command_q[7:6], addr_high_q, addr_low_q};
    wire [3:0]  cmd_op   = command_q[3:0];
    wire        go_bad   = !cmd_ok(cmd_op, command_q[`IFP_CN_FIRST_CLASS],
                                   command_q[`IFP_CN_SECOND_CLASS]) ||
                           illegal(command_q[7:6], cmd_op, tgt_addr[15:0],
                                   code_in_loader, loader_update_enable_q);
    wire        fault_set = go && go_bad;

    assign rc_osc_en = prog_en_q;

    // ------------------------------------------------------------------
    // timed access: AAh then 55h opens one protected write
    // ------------------------------------------------------------------
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            ta_q <= 2'd0;
        else if (wr_ta && (sfr_wdata == `IFP_TA_KEY1))
            ta_q <= 2'd1;
        else if (wr_ta && (sfr_wdata == `IFP_TA_KEY2) && (ta_q == 2'd1))
            ta_q <= 2'd2;
        else if (sfr_wr)
            ta_q <= 2'd0;
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_low_q     <= `IFP_RST_BYTE;
            addr_high_q    <= `IFP_RST_BYTE;
            command_q      <= `IFP_RST_BYTE;
            prog_en_q      <= 1'b0;
            loader_update_enable_q        <= 1'b0;
            boot_next_q    <= 1'b0;
            sw_reset_req_q <= 1'b0;
            fault_q        <= 1'b0;
        end
        else
        begin
            sw_reset_req_q <= wr_cc && sfr_wdata[`IFP_CC_SWRST];
            if (sfr_wr && (sfr_addr == `IFP_SFR_ADDR_LOW))
                addr_low_q <= sfr_wdata;
            if (sfr_wr && (sfr_addr == `IFP_SFR_ADDR_HIGH))
                addr_high_q <= sfr_wdata;
            if (sfr_wr && (sfr_addr == `IFP_SFR_COMMAND))
                command_q <= sfr_wdata;
            if (wr_cc)
            begin
                prog_en_q   <= sfr_wdata[`IFP_CC_PROG_EN];
                loader_update_enable_q     <= sfr_wdata[`IFP_CC_LOADER_UPDATE_ENABLE];
                boot_next_q <= sfr_wdata[`IFP_CC_BOOTSEL];
            end
            // a new fault wins over a clear in the same cycle
            if (fault_set)
                fault_q <= 1'b1;
            else if (wr_cc && !sfr_wdata[`IFP_CC_FAULT])
                fault_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            sfr_rdata_q <= `IFP_RST_BYTE;
        else if (sfr_rd)
        begin
            case (sfr_addr)
                `IFP_SFR_ADDR_LOW:  sfr_rdata_q <= addr_low_q;
                `IFP_SFR_ADDR_HIGH: sfr_rdata_q <= addr_high_q;
                `IFP_SFR_DATA:      sfr_rdata_q <= data_q;
                `IFP_SFR_COMMAND:   sfr_rdata_q <= command_q;
                `IFP_SFR_CHIP_CTRL: sfr_rdata_q <= {1'b0, fault_q, loader_update_enable_q, 3'b000,
                                                    boot_from_loader, prog_en_q};
                default:            sfr_rdata_q <= `IFP_RST_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // operation sequencer
    // ------------------------------------------------------------------
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q    <= S_IDLE;
            op_q       <= `IFP_OP_READ;
            cnt_q      <= 2'd0;
            data_q     <= `IFP_RST_BYTE;
            cpu_hold_q <= 1'b0;
            fl_req_q   <= 1'b0;
            fl_cmd_q   <= `IFP_FCMD_READ;
            fl_addr_q  <= 18'h00000;
            fl_wdata_q <= `IFP_RST_BYTE;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (sfr_wr && (sfr_addr == `IFP_SFR_DATA))
                        data_q <= sfr_wdata;
                    if (go)
                    begin
                        cpu_hold_q <= 1'b1;
                        op_q       <= cmd_op;
                        fl_addr_q  <= tgt_addr;
                        fl_wdata_q <= data_q;
                        cnt_q      <= 2'd0;
                        if (go_bad)
                            state_q <= S_DONE;
                        else if (cmd_op == `IFP_OP_MFR_ID)
                        begin
                            data_q  <= MFR_ID;
                            state_q <= S_DONE;
                        end
                        else if (cmd_op == `IFP_OP_DEV_ID)
                        begin
                            data_q  <= tgt_addr[0] ? DEV_ID[15:8] : DEV_ID[7:0];
                            state_q <= S_DONE;
                        end
                        else if (command_q[7:6] == `IFP_RGN_CONFIG)
                        begin
                            if (cmd_op == `IFP_OP_ERASE)
                                state_q <= S_CFGER;
                            else if (cmd_op == `IFP_OP_PROG)
                                state_q <= S_CFGWR;
                            else
                                state_q <= S_CFGRD;
                        end
                        else
                        begin
                            fl_req_q <= 1'b1;
                            state_q  <= S_FLASH;
                            case (cmd_op)
                                `IFP_OP_ERASE: fl_cmd_q <= `IFP_FCMD_ERASE;
                                `IFP_OP_PROG:  fl_cmd_q <= `IFP_FCMD_PROG;
                                default:       fl_cmd_q <= `IFP_FCMD_READ;
                            endcase
                        end
                    end
                end
                S_FLASH:
                begin
                    if (fl_done)
                    begin
                        fl_req_q <= 1'b0;
                        if (op_q == `IFP_OP_READ)
                            data_q <= fl_rdata;
                        state_q <= S_DONE;
                    end
                end
                S_CFGRD:
                    state_q <= S_CFGLT;
                S_CFGLT:
                begin
                    data_q  <= mem_rdata;
                    state_q <= S_DONE;
                end
                S_CFGWR:
                    state_q <= S_DONE;
                S_CFGER:
                begin
                    cnt_q <= cnt_q + 2'd1;
                    if (cnt_q == 2'd3)
                        state_q <= S_DONE;
                end
                S_DONE:
                begin
                    cpu_hold_q <= 1'b0;
                    state_q    <= S_IDLE;
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // config store port
    // ------------------------------------------------------------------
    always @*
    begin
        mem_we    = 1'b0;
        mem_addr  = fl_addr_q[1:0];
        mem_wdata = fl_wdata_q;
        if (cap_q != 2'd0)
            mem_addr = 2'd0;
        else if (state_q == S_CFGWR)
            mem_we = 1'b1;
        else if (state_q == S_CFGER)
        begin
            mem_we    = 1'b1;
            mem_addr  = cnt_q;
            mem_wdata = `IFP_ERASED_BYTE;
        end
    end

    ifp_cfg_mem #(
        .DW    (8),
        .DEPTH (`IFP_CFG_BYTES),
        .AW    (2)
    ) u_cfg_mem (
        .sys_clk (sys_clk),
        .por_n   (por_n),
        .we      (mem_we),
        .addr    (mem_addr),
        .wdata   (mem_wdata),
        .rdata_q (mem_rdata),
        .word0   (mem_word0)
    );

    // ------------------------------------------------------------------
    // config takes effect only when a reset is released
    // ------------------------------------------------------------------
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            cap_q <= 2'd2;
        else if (cap_q != 2'd0)
            cap_q <= cap_q - 2'd1;
    end

    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg0_active_q <= `IFP_ERASED_BYTE;
            lock_active_q <= 1'b0;
        end
        else if (cap_q == 2'd1)
        begin
            cfg0_active_q <= mem_rdata;
            lock_active_q <= mem_rdata[`IFP_CFG0_LOCK];
        end
    end

    // boot bit survives a software reset, so it is cleared by power-on only
    always @(posedge sys_clk or negedge por_n)
    begin
        if (!por_n)
            boot_select_active_q <= 1'b0;
        else if ((cap_q == 2'd1) && !last_reset_sw)
            boot_select_active_q <= mem_word0[`IFP_CFG0_BOOTSEL];
    end

endmodule // ifp_top

/* dv/ifp_asserts.sv */
`timescale 1ns/1ps
module ifp_asserts (
    input wire        sys_clk,
    input wire        nrst,
    input wire [7:0]  sfr_addr,
    input wire        sfr_wr,
    input wire        sfr_rd,
    input wire [7:0]  sfr_wdata,
    input wire [7:0]  sfr_rdata_q,
    input wire        cpu_hold_q,
    input wire        rc_osc_en,
    input wire        fl_req_q,
    input wire        fl_done,
    input wire [1:0]  fl_cmd_q,
    input wire [17:0] fl_addr_q,
    input wire [7:0]  fl_wdata_q
);
    reg  [1:0] ta_q;
    reg  [7:0] lo_q;
    reg  [7:0] hi_q;
    reg  [7:0] cn_q;
    reg  [7:0] fd_q;
    wire       go  = sfr_wr && sfr_addr == 8'hA4 && sfr_wdata[0];
    wire       key = sfr_wr && sfr_addr == 8'hC7;
    // ----
    // unlock tracker and shadows
    // ----
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            ta_q <= 2'h0;
        else if (sfr_wr)
            ta_q <= (key && sfr_wdata == 8'hAA) ? 2'h1 :
                    (key && sfr_wdata == 8'h55 && ta_q == 2'h1) ? 2'h2 : 2'h0;
    end
    // shadows are not reset: every operation rewrites them first
    always @(posedge sys_clk)
    begin
        if (sfr_wr && sfr_addr == 8'hA6)
            lo_q <= sfr_wdata;
        if (sfr_wr && sfr_addr == 8'hA7)
            hi_q <= sfr_wdata;
        if (sfr_wr && sfr_addr == 8'hAF)
            cn_q <= sfr_wdata;
        if (sfr_wr && sfr_addr == 8'hAE)
            fd_q <= sfr_wdata;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    property p_go_hold;
        go && ta_q == 2'h2 && rc_osc_en && !cpu_hold_q |=> cpu_hold_q;
    endproperty
    a_go_hold: assert property (p_go_hold) else $error("go left cpu running");
    property p_ta_refuse;
        go && ta_q != 2'h2 && !cpu_hold_q |=> !cpu_hold_q;
    endproperty
    a_ta_refuse: assert property (p_ta_refuse) else $error("locked go started");
    property p_hold_end;
        $rose(cpu_hold_q) |-> ##[1:40] !cpu_hold_q;
    endproperty
    a_hold_end: assert property (p_hold_end) else $error("cpu never released");
    property p_done;
        fl_req_q && fl_done |=> !fl_req_q && cpu_hold_q ##1 !cpu_hold_q;
    endproperty
    a_done: assert property (p_done) else $error("bad completion timing");
    property p_req_hold;
        fl_req_q |-> cpu_hold_q;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("flash busy, cpu free");
    property p_addr;
        $rose(fl_req_q) |-> fl_addr_q == {cn_q[7:6], hi_q, lo_q};
    endproperty
    a_addr: assert property (p_addr) else $error("wrong flash address");
    property p_cmd;
        $rose(fl_req_q) |-> fl_cmd_q == (cn_q[1] ? 2'h2 : {1'b0, cn_q[0]});
    endproperty
    a_cmd: assert property (p_cmd) else $error("wrong flash command");
    property p_wdata;
        $rose(fl_req_q) && fl_cmd_q == 2'h1 |-> fl_wdata_q == fd_q;
    endproperty
    a_wdata: assert property (p_wdata) else $error("wrong program data");
    property p_trg_read;
        sfr_rd && sfr_addr == 8'hA4 |=> sfr_rdata_q == 8'h00;
    endproperty
    a_trg_read: assert property (p_trg_read) else $error("trigger read nonzero");
    property p_osc;
        sfr_wr && sfr_addr == 8'h9F |=>
            rc_osc_en == ($past(ta_q) == 2'h2 ? $past(sfr_wdata[0]) : $past(rc_osc_en));
    endproperty
    a_osc: assert property (p_osc) else $error("enable bit misbehaved");
    c_go: cover property (go && ta_q == 2'h2 && rc_osc_en);
    c_erase: cover property (fl_req_q && fl_done && fl_cmd_q == 2'h2);
    c_id: cover property ($rose(cpu_hold_q) && !fl_req_q);
endmodule // ifp_asserts
bind ifp_top ifp_asserts u_chk (.*);

/* dv/ifp_flash_model.sv */
`timescale 1ns/1ps
module ifp_flash_model (
    input  wire        sys_clk,
    input  wire [3:0]  dly,
    input  wire        fl_req_q,
    input  wire [1:0]  fl_cmd_q,
    input  wire [17:0] fl_addr_q,
    input  wire [7:0]  fl_wdata_q,
    output reg  [7:0]  fl_rdata,
    output reg         fl_done
);
    reg     [7:0] mem [0:511];
    reg     [3:0] cnt_q;
    wire    [8:0] ix = {fl_addr_q[16], fl_addr_q[7:0]};
    integer       i;
    initial
    begin
        for (i = 0; i < 512; i = i + 1)
            mem[i] = 8'hFF;
        cnt_q = 4'h0;
        fl_done = 1'b0;
        fl_rdata = 8'h00;
    end
    // data lines toggle outside done so a late sample never matches by luck
    always @(posedge sys_clk)
    begin
        fl_rdata <= ~fl_rdata;
        fl_done <= 1'b0;
        cnt_q <= 4'h0;
        if (fl_req_q && !fl_done)
        begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == dly)
            begin
                fl_done <= 1'b1;
                fl_rdata <= mem[ix];
                // programming can only clear bits, as real cells do
                if (fl_cmd_q == 2'h1)
                    mem[ix] <= mem[ix] & fl_wdata_q;
                if (fl_cmd_q == 2'h2)
                    for (i = 0; i < 128; i = i + 1)
                        mem[{ix[8:7], i[6:0]}] <= 8'hFF;
            end
        end
    end
endmodule // ifp_flash_model

/* dv/tb_inapp_flash_programmer.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
    num_errors = num_errors + 1; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_inapp_flash_programmer;
    localparam [7:0]  MFR = 8'h5A;    // arbitrary value
    localparam [15:0] DEV = 16'hA7C3; // arbitrary value
    reg         sys_clk;
    reg         nrst;
    reg         por_n;
    reg         sfr_wr = 1'b0;
    reg         sfr_rd = 1'b0;
    reg         code_in_loader = 1'b1;
    reg         rd_seen_q = 1'b0;
    reg  [7:0]  sfr_addr = 8'h00;
    reg  [7:0]  sfr_wdata = 8'h00;
    reg  [3:0]  dly = 4'h0;
    reg  [7:0]  d;
    reg  [7:0]  ev;
    reg         lsw = 1'b0;
    reg  [15:0] p;
    reg  [15:0] b;
    reg  [7:0]  exp_q [$];
    wire [7:0]  sfr_rdata_q, fl_rdata, fl_wdata_q, cfg0;
    wire [17:0] fl_addr_q;
    wire [1:0]  fl_cmd_q;
    wire        cpu_hold_q, rc_osc_en, fl_req_q, fl_done, lock_act, bsa;
    integer     num_errors = 0;
    integer     compares = 0;
    integer     seed = 32'hAE67;
    integer     n;
    integer     k;
    ifp_top #(.MFR_ID(MFR), .DEV_ID(DEV)) u_dut (
        .sys_clk(sys_clk), .nrst(nrst), .por_n(por_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
        .code_in_loader(code_in_loader), .last_reset_sw(lsw), .boot_from_loader(1'b0),
        .cpu_hold_q(cpu_hold_q), .rc_osc_en(rc_osc_en), .sw_reset_req_q(), .boot_next_q(),
        .boot_select_active_q(bsa), .lock_active_q(lock_act), .cfg0_active_q(cfg0),
        .fl_req_q(fl_req_q), .fl_cmd_q(fl_cmd_q), .fl_addr_q(fl_addr_q),
        .fl_wdata_q(fl_wdata_q), .fl_rdata(fl_rdata), .fl_done(fl_done));
    ifp_flash_model u_flash (
        .sys_clk(sys_clk), .dly(dly), .fl_req_q(fl_req_q), .fl_cmd_q(fl_cmd_q),
        .fl_addr_q(fl_addr_q), .fl_wdata_q(fl_wdata_q), .fl_rdata(fl_rdata), .fl_done(fl_done));
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // read data lands one edge after the strobe
    always @(posedge sys_clk)
    begin
        if (rd_seen_q)
        begin
            ev = exp_q.pop_front();
            `CHK(sfr_rdata_q, ev)
        end
        rd_seen_q <= sfr_rd;
    end
    task wr(input [7:0] a, input [7:0] v);
    begin
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
    end
    endtask
    task rd(input [7:0] a, input [7:0] e);
    begin
        @(posedge sys_clk);
        exp_q.push_back(e);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
    end
    endtask
    task prot(input [7:0] a, input [7:0] v);
    begin
        wr(8'hC7, 8'hAA);
        wr(8'hC7, 8'h55);
        wr(a, v);
    end
    endtask
    task op(input [7:0] c, input [15:0] a, input [7:0] v);
    begin
        dly <= $random(seed);
        wr(8'hAF, c);
        wr(8'hA7, a[15:8]);
        wr(8'hA6, a[7:0]);
        wr(8'hAE, v);
        prot(8'hA4, 8'h01);
        n = 0;
        @(posedge sys_clk);
        `CHK(cpu_hold_q, 1'b1)
        while (cpu_hold_q !== 1'b0 && n < 64)
        begin
            @(posedge sys_clk);
            n = n + 1;
        end
        `CHK(n < 64, 1'b1)
    end
    endtask
    task rst;
    begin
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    end
    endtask
    task give_verdict;
    begin
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    initial
    begin
        por_n = 1'b0;
        rst;
        rd(8'hA6, 8'h00);
        rd(8'hA7, 8'h00);
        rd(8'hAE, 8'h00);
        rd(8'hA4, 8'h00);
        rd(8'h80, 8'h00);
        d = $random(seed);
        wr(8'hA6, d);
        rd(8'hA6, d);
        wr(8'hA7, ~d);
        rd(8'hA7, ~d);
        prot(8'hA4, 8'h01);
        @(posedge sys_clk);
        `CHK(cpu_hold_q, 1'b0)
        wr(8'h9F, 8'h01);
        rd(8'h9F, 8'h00);
        prot(8'h9F, 8'h01);
        rd(8'h9F, 8'h01);
        wr(8'hA4, 8'h01);
        @(posedge sys_clk);
        `CHK(cpu_hold_q, 1'b0)
        $display("test registers done");
        op(8'hCB, 16'h1234, 8'h00);
        rd(8'hAE, MFR);
        op(8'h0C, 16'h0000, 8'h00);
        rd(8'hAE, DEV[7:0]);
        op(8'h4C, 16'h0001, 8'h00);
        rd(8'hAE, DEV[15:8]);
        $display("test ident done");
        for (k = 0; k < 4; k = k + 1)
        begin
            p = 16'h3F80 & $random(seed);
            b = p | (16'h007F & $random(seed));
            d = $random(seed);
            op(8'h22, p, d);
            op(8'h00, b, 8'h00);
            rd(8'hAE, 8'hFF);
            op(8'h21, b, d);
            op(8'h00, b, ~d);
            rd(8'hAE, d);
        end
        $display("test flash done");
        code_in_loader <= 1'b0;
        op(8'h21, b, 8'h00);
        rd(8'h9F, 8'h41);
        op(8'h00, b, 8'h00);
        rd(8'hAE, d);
        op(8'hC0, 16'h0000, 8'h00);
        rd(8'hAE, 8'h00);
        prot(8'h9F, 8'h01);
        rd(8'h9F, 8'h01);
        code_in_loader <= 1'b1;
        op(8'h22, p | 16'h0001, 8'h00);
        rd(8'h9F, 8'h41);
        op(8'h40, 16'h0000, 8'h00);
        rd(8'hAE, 8'hFF);
        $display("test faults done");
        op(8'hE2, 16'h0000, 8'h00);
        op(8'hC0, 16'h0002, 8'h00);
        rd(8'hAE, 8'hFF);
        op(8'hE1, 16'h0000, 8'hF2);
        op(8'hC0, 16'h0000, 8'h00);
        rd(8'hAE, 8'hF2);
        @(posedge sys_clk);
        rst;
        `CHK(cfg0, 8'hF2)
        `CHK(bsa, 1'b1)
        `CHK(lock_act, 1'b1)
        rd(8'h9F, 8'h00);
        prot(8'h9F, 8'h01);
        op(8'hC0, 16'h0000, 8'h00);
        rd(8'hAE, 8'hF2);
        op(8'hE1, 16'h0000, 8'h72);
        prot(8'h9F, 8'h00);
        rd(8'h9F, 8'h00);
        @(posedge sys_clk);
        lsw <= 1'b1;
        rst;
        `CHK(bsa, 1'b1)
        `CHK(cfg0, 8'h72)
        $display("test config done");
        repeat (2) @(posedge sys_clk);
        give_verdict;
    end
    // far beyond the thousand or so cycles the sequence needs; the limit is 20000 cycles
    initial
    begin
        #800000;
        num_errors = num_errors + 1;
        give_verdict;
    end
endmodule // tb_inapp_flash_programmer
